// ===== bench/mgc_hold_partner.sv
// Model of an external master that borrows the memory interface through the hold pins.
// Assumes the bench asks for the bus with want_bus and that everything runs on mclk.
`timescale 1ns/1ps

module mgc_hold_partner (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    // Request from the bench
    input  wire logic want_bus,
    // Hold pins, and the ownership flag made from them
    input  wire logic hold_acknowledge_b,
    output logic      hold_request_b,
    output logic      owns_bus
);
    // The request is never dropped before the grant, so a slow grant is simply waited out.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hold_request_b <= 1'b1;
        end else if (want_bus || !hold_acknowledge_b) begin
            hold_request_b <= !want_bus;
        end
    end
    assign owns_bus = !hold_request_b && !hold_acknowledge_b;
endmodule

// ===== bench/tb.sv
// Self-checking bench for the global interface control register and its clock outputs.
// Assumes the design answers each bus request with waitrequest low one cycle later.
`timescale 1ns/1ps

module tb;
    // Full rate with every clock enabled; once software has set full rate it never moves the rate again.
    localparam logic [31:0] BASE = 32'h0001_2078;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic access_pending = 1'b0;
    logic refresh_pending = 1'b0;
    logic async_ready_input = 1'b0;
    logic want_bus = 1'b0;
    logic hold_request_b;
    logic hold_acknowledge_b;
    logic bus_request;
    logic owns_bus;
    logic aux4;
    logic aux6;
    mgc_pkg::mgc_clk_pin_t p1;
    mgc_pkg::mgc_clk_pin_t p2;
    logic [3:0] prv;
    logic [31:0] q;
    int c1, c2, c4, c6, cyc, miscompares, cmp_count;

    always #2.5 mclk = ~mclk;

    mgc_global_ctl DUT (
        .mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .access_pending(access_pending), .refresh_pending(refresh_pending),
        .async_ready_input(async_ready_input), .hold_request_b(hold_request_b),
        .hold_acknowledge_b(hold_acknowledge_b), .bus_request(bus_request),
        .first_ext_clock_out(p1), .second_ext_clock_out(p2),
        .aux_div4_clock_out(aux4), .aux_div6_clock_out(aux6)
    );

    mgc_hold_partner partner (
        .mclk(mclk), .rst_b(rst_b), .want_bus(want_bus),
        .hold_acknowledge_b(hold_acknowledge_b), .hold_request_b(hold_request_b), .owns_bus(owns_bus)
    );

    // Rising edges are counted on mclk samples, since every output comes from a flop.
    always @(posedge mclk) begin
        prv <= {aux6, p2.clk, p1.clk, aux4};
        c2 = c2 + int'(p2.clk && !prv[2]);
        c1 = c1 + int'(p1.clk && !prv[1]);
        c4 = c4 + int'(aux4 && !prv[0]);
        c6 = c6 + int'(aux6 && !prv[3]);
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // Holds the request until waitrequest is sampled low; the timeout ends a hang.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // The window is 96 cycles, a whole number of periods of every clock, so each count is exact.
    // Switching is not glitch free, so counting starts only after the outputs have settled.
    task automatic measure();
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        {c1, c2, c4, c6} = '0;
        repeat (96) @(posedge mclk);
        @(negedge mclk);
    endtask

    initial begin
        {c1, c2, c4, c6, cyc, miscompares, cmp_count} = '0;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (8) @(posedge mclk);
        bus(1'b0, 4'h0, 32'h0);
        chk(q, 32'h0009_2378);
        // The rate field is written with its quarter-rate default, so the rate does not change here.
        bus(1'b1, 4'h0, 32'hfffb_ffff);
        bus(1'b0, 4'h0, 32'h0);
        chk(q, 32'h000b_23f8);
        avs_byteenable <= 4'h2;
        bus(1'b1, 4'h0, 32'h0);
        avs_byteenable <= 4'hf;
        bus(1'b0, 4'h0, 32'h0);
        chk(q, 32'h000b_03f8);
        bus(1'b0, 4'h4, 32'h0);
        chk(q, 32'h0);
        $display("register map test done");
        measure();
        chk(32'(c2), 32'd12);
        bus(1'b1, 4'h0, BASE | 32'h0004_0000);
        measure();
        chk(32'(c2), 32'd24);
        // A second reset starts a new initialisation, which allows one more rate change.
        rst_b <= 1'b0;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (8) @(posedge mclk);
        bus(1'b0, 4'h0, 32'h0);
        chk(q, 32'h0009_2378);
        bus(1'b1, 4'h0, BASE);
        measure();
        chk(32'(c2), 32'd48);
        chk(32'(c1), 32'd48);
        chk(32'(c4), 32'd24);
        chk(32'(c6), 32'd16);
        bus(1'b1, 4'h0, 32'h0000_2040);
        measure();
        chk({c2[7:0], c1[7:0], c4[7:0], c6[7:0]}, 32'h0);
        chk({p2.clk, p1.clk, aux4, aux6}, 32'h3);
        $display("clock test done");
        bus(1'b1, 4'h0, BASE);
        refresh_pending <= 1'b1;
        async_ready_input <= 1'b1;
        repeat (6) @(posedge mclk);
        bus(1'b0, 4'h0, 32'h0);
        chk(q[11:10], 2'h3);
        chk(bus_request, 1'b1);
        bus(1'b1, 4'h0, BASE & 32'hffff_dfff);
        repeat (3) @(posedge mclk);
        chk(bus_request, 1'b0);
        access_pending <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(bus_request, 1'b1);
        access_pending <= 1'b0;
        refresh_pending <= 1'b0;
        $display("bus request test done");
        bus(1'b1, 4'h0, (BASE | 32'h0002_0000) & 32'hffff_ffbf);
        want_bus <= 1'b1;
        repeat (10) @(posedge mclk);
        chk(owns_bus, 1'b1);
        chk({p2.oe, p1.oe}, 2'h1);
        bus(1'b0, 4'h0, 32'h0);
        chk(q[9:8], 2'h0);
        want_bus <= 1'b0;
        repeat (10) @(posedge mclk);
        chk({hold_acknowledge_b, p2.oe}, 2'h3);
        bus(1'b1, 4'h0, BASE | 32'h0000_0080);
        want_bus <= 1'b1;
        repeat (20) @(posedge mclk);
        chk(hold_acknowledge_b, 1'b1);
        want_bus <= 1'b0;
        $display("hold test done");
        finish_test();
    end
endmodule

// ===== inc/mgc_defs.svh
// Offsets, field positions, reset values and counts of the global interface control register.
// Included by the package and by the design file; definitions only.
`ifndef MGC_DEFS_SVH
`define MGC_DEFS_SVH

`define MGC_GLOBAL_CTL_OFFSET  4'h0
`define MGC_ADDR_W             4

`define MGC_RATE_HI            19
`define MGC_RATE_LO            18
`define MGC_CLK2_HZ_BIT        17
`define MGC_CLK2_EN_BIT        16
`define MGC_BUS_REQUEST_MODE_BIT         13
`define MGC_BUS_REQUEST_STATUS_BIT         11
`define MGC_READY_BIT          10
`define MGC_HOLDREQ_BIT        9
`define MGC_HOLDACK_BIT        8
`define MGC_HOLD_DISABLE_BIT         7
`define MGC_CLK1_HZ_BIT        6
`define MGC_CLK1_EN_BIT        5
`define MGC_DIV4_EN_BIT        4
`define MGC_DIV6_EN_BIT        3

`define MGC_RESERVED_MASK      32'hfff0_d007

`define MGC_RATE_RST           2'h2
`define MGC_CLK2_HZ_RST        1'h0
`define MGC_CLK2_EN_RST        1'h1
`define MGC_BUS_REQUEST_MODE_RST         1'h1
`define MGC_HOLD_DISABLE_RST         1'h0
`define MGC_CLK1_HZ_RST        1'h1
`define MGC_CLK1_EN_RST        1'h1
`define MGC_DIV4_EN_RST        1'h1
`define MGC_DIV6_EN_RST        1'h1

`define MGC_DIV4_HALF          2'h2
`define MGC_DIV6_HALF          2'h3

`endif

// ===== inc/mgc_pkg.sv
// Types shared by the global interface control block.
// Assumes mgc_defs.svh is on the include path.
`include "mgc_defs.svh"

package mgc_pkg;

    typedef enum logic [1:0] {
        MGC_RATE_FULL    = 2'h0,
        MGC_RATE_HALF    = 2'h1,
        MGC_RATE_QUARTER = 2'h2,
        MGC_RATE_RSVD    = 2'h3
    } mgc_rate_t;

    typedef enum logic [0:0] {
        MGC_HOLD_OWN  = 1'h0,
        MGC_HOLD_LENT = 1'h1
    } mgc_hold_state_t;

    typedef struct packed {
        mgc_rate_t rate;
        logic      clk2_float;
        logic      clk2_en;
        logic      bus_request_mode;
        logic      hold_disable;
        logic      clk1_float;
        logic      clk1_en;
        logic      div4_en;
        logic      div6_en;
    } mgc_ctl_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [`MGC_ADDR_W-1:0] address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } mgc_avs_req_t;

    typedef struct packed {
        logic        clk;
        logic        oe;
    } mgc_clk_pin_t;

endpackage

// ===== rtl/mgc_global_ctl.sv
// Global control and status register of an external memory interface, with its clock outputs.
// Assumes one clock, an Avalon-MM master on the register side, and pins on the memory side.
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`include "mgc_defs.svh"

module mgc_global_ctl (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_b,
    // Avalon-MM slave
    input  wire logic [`MGC_ADDR_W-1:0] avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [3:0]            avs_byteenable,
    input  wire logic [31:0]           avs_writedata,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    // Memory controller status, same clock
    input  wire logic                  access_pending,
    input  wire logic                  refresh_pending,
    // Pins from the outside world
    input  wire logic                  async_ready_input,
    input  wire logic                  hold_request_b,
    // Pins to the outside world
    output logic                       hold_acknowledge_b,
    output logic                       bus_request,
    output mgc_pkg::mgc_clk_pin_t      first_ext_clock_out,
    output mgc_pkg::mgc_clk_pin_t      second_ext_clock_out,
    output logic                       aux_div4_clock_out,
    output logic                       aux_div6_clock_out
);
    import mgc_pkg::*;

    mgc_ctl_t        ctl;
    mgc_hold_state_t hold_state;
    mgc_hold_state_t next_hold_state;
    mgc_avs_req_t    req;
    logic [2:0]      ready_sync;
    logic [2:0]      hold_sync;
    logic            ready_seen;
    logic            hold_req_seen_b;
    logic [2:0]      phase_cnt;
    logic [1:0]      div4_cnt;
    logic [1:0]      div6_cnt;

    assign req = '{read: avs_read, write: avs_write, address: avs_address,
                   byteenable: avs_byteenable, writedata: avs_writedata};

    // Bus decode.  A request is answered one cycle after it is first seen.
    wire        reg_hit    = (req.address == `MGC_GLOBAL_CTL_OFFSET);
    wire        req_first  = (req.read | req.write) & avs_waitrequest;
    wire        req_done   = (req.read | req.write) & ~avs_waitrequest;
    wire        ctl_write  = req_done & req.write & reg_hit;
    wire [31:0] status_word = {12'h000,
                               ctl.rate, ctl.clk2_float, ctl.clk2_en,
                               2'h0, ctl.bus_request_mode, 1'h0,
                               bus_request, ready_seen, hold_req_seen_b, hold_acknowledge_b,
                               ctl.hold_disable, ctl.clk1_float, ctl.clk1_en, ctl.div4_en, ctl.div6_en,
                               3'h0};
    wire [31:0] next_readdata = reg_hit ? status_word : 32'h0000_0000;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'h1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~req_first;
            if (req_first && req.read) begin
                avs_readdata <= next_readdata;
            end
        end
    end

    // Only writable fields are stored; status and reserved bits have no storage to hit.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctl.rate             <= mgc_rate_t'(`MGC_RATE_RST);
            ctl.clk2_float       <= `MGC_CLK2_HZ_RST;
            ctl.clk2_en          <= `MGC_CLK2_EN_RST;
            ctl.bus_request_mode <= `MGC_BUS_REQUEST_MODE_RST;
            ctl.hold_disable     <= `MGC_HOLD_DISABLE_RST;
            ctl.clk1_float       <= `MGC_CLK1_HZ_RST;
            ctl.clk1_en          <= `MGC_CLK1_EN_RST;
            ctl.div4_en          <= `MGC_DIV4_EN_RST;
            ctl.div6_en          <= `MGC_DIV6_EN_RST;
        end else if (ctl_write) begin
            if (req.byteenable[2]) begin
                ctl.rate       <= mgc_rate_t'(req.writedata[`MGC_RATE_HI:`MGC_RATE_LO]);
                ctl.clk2_float <= req.writedata[`MGC_CLK2_HZ_BIT];
                ctl.clk2_en    <= req.writedata[`MGC_CLK2_EN_BIT];
            end
            if (req.byteenable[1]) begin
                ctl.bus_request_mode <= req.writedata[`MGC_BUS_REQUEST_MODE_BIT];
            end
            if (req.byteenable[0]) begin
                ctl.hold_disable <= req.writedata[`MGC_HOLD_DISABLE_BIT];
                ctl.clk1_float   <= req.writedata[`MGC_CLK1_HZ_BIT];
                ctl.clk1_en      <= req.writedata[`MGC_CLK1_EN_BIT];
                ctl.div4_en      <= req.writedata[`MGC_DIV4_EN_BIT];
                ctl.div6_en      <= req.writedata[`MGC_DIV6_EN_BIT];
            end
        end
    end

    // Pin inputs pass three flops; the filtered level moves only when the last two agree.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ready_sync      <= 3'h0;
            hold_sync       <= 3'h7;
            ready_seen      <= 1'h0;
            hold_req_seen_b <= 1'h1;
        end else begin
            ready_sync <= {ready_sync[1:0], async_ready_input};
            hold_sync  <= {hold_sync[1:0], hold_request_b};
            if (ready_sync[2] == ready_sync[1]) begin
                ready_seen <= ready_sync[2];
            end
            if (hold_sync[2] == hold_sync[1]) begin
                hold_req_seen_b <= hold_sync[2];
            end
        end
    end

    // Hold is granted only between accesses, which is the earliest safe point.
    always_comb begin
        next_hold_state = hold_state;
        case (hold_state)
            MGC_HOLD_OWN: begin
                if (!hold_req_seen_b && !ctl.hold_disable && !access_pending) begin
                    next_hold_state = MGC_HOLD_LENT;
                end
            end
            MGC_HOLD_LENT: begin
                if (hold_req_seen_b) begin
                    next_hold_state = MGC_HOLD_OWN;
                end
            end
            default: next_hold_state = MGC_HOLD_OWN;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hold_state         <= MGC_HOLD_OWN;
            hold_acknowledge_b <= 1'h1;
            bus_request        <= 1'h0;
        end else begin
            hold_state         <= next_hold_state;
            hold_acknowledge_b <= (next_hold_state != MGC_HOLD_LENT);
            bus_request        <= access_pending | (ctl.bus_request_mode & refresh_pending);
        end
    end

    // Clock generation.  Enables and floats act at once, so switching is not glitch free.
    wire hold_lent = (hold_state == MGC_HOLD_LENT);
    wire rate_phase = (ctl.rate == MGC_RATE_FULL) ? phase_cnt[0] :
                      (ctl.rate == MGC_RATE_HALF) ? phase_cnt[1] : phase_cnt[2];
    wire div4_wrap = (div4_cnt == `MGC_DIV4_HALF - 2'h1);
    wire div6_wrap = (div6_cnt == `MGC_DIV6_HALF - 2'h1);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            phase_cnt <= 3'h0;
            div4_cnt  <= 2'h0;
            div6_cnt  <= 2'h0;
        end else begin
            phase_cnt <= phase_cnt + 3'h1;
            div4_cnt  <= div4_wrap ? 2'h0 : div4_cnt + 2'h1;
            div6_cnt  <= div6_wrap ? 2'h0 : div6_cnt + 2'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            first_ext_clock_out  <= '{clk: 1'h0, oe: 1'h1};
            second_ext_clock_out <= '{clk: 1'h0, oe: 1'h1};
            aux_div4_clock_out   <= 1'h1;
            aux_div6_clock_out   <= 1'h1;
        end else begin
            second_ext_clock_out.clk <= ctl.clk2_en & rate_phase;
            second_ext_clock_out.oe  <= ~(ctl.clk2_float & hold_lent);
            first_ext_clock_out.clk  <= ctl.clk1_en & ~first_ext_clock_out.clk;
            first_ext_clock_out.oe   <= ~(ctl.clk1_float & hold_lent);
            aux_div4_clock_out <= ctl.div4_en ? (aux_div4_clock_out ^ div4_wrap) : 1'h1;
            aux_div6_clock_out <= ctl.div6_en ? (aux_div6_clock_out ^ div6_wrap) : 1'h1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence s_hold_asked;
        !hold_req_seen_b && !ctl.hold_disable && !access_pending && hold_state == MGC_HOLD_OWN;
    endsequence

    sequence s_full_steady;
        (ctl.clk2_en && ctl.rate == MGC_RATE_FULL)[*2];
    endsequence

    chk_clk2_full_toggle: assert property (s_full_steady |=> second_ext_clock_out.clk != $past(second_ext_clock_out.clk))
        else $error("second clock does not toggle at full rate");
    chk_clk2_float_hold: assert property (ctl.clk2_float && hold_lent |=> !second_ext_clock_out.oe)
        else $error("second clock not floated during hold");
    chk_clk2_held_low: assert property (!ctl.clk2_en |=> !second_ext_clock_out.clk)
        else $error("disabled second clock not low");
    chk_bus_request_status_mode: assert property (!ctl.bus_request_mode && !access_pending |=> !bus_request)
        else $error("bus request shows refresh in access-only mode");
    chk_bus_request_status_mirror: assert property (req_first && req.read && reg_hit
                                       |=> avs_readdata[`MGC_BUS_REQUEST_STATUS_BIT] == $past(bus_request))
        else $error("bus request status bit does not mirror output");
    chk_reserved_zero: assert property (!avs_waitrequest |-> (avs_readdata & `MGC_RESERVED_MASK) == 32'h0000_0000)
        else $error("reserved bits read nonzero");
    chk_hold_ignored: assert property (ctl.hold_disable && hold_state == MGC_HOLD_OWN |=> hold_acknowledge_b)
        else $error("hold acknowledged while disabled");
    chk_hold_grant: assert property (s_hold_asked |=> !hold_acknowledge_b ##1 1)
        else $error("hold not acknowledged at earliest time");
    chk_aux_held_high: assert property (!ctl.div4_en || !ctl.div6_en
                                        |=> (aux_div4_clock_out || $past(ctl.div4_en))
                                            && (aux_div6_clock_out || $past(ctl.div6_en)))
        else $error("disabled auxiliary clock not high");
    chk_clk1_held_low: assert property (!ctl.clk1_en |=> !first_ext_clock_out.clk)
        else $error("disabled first clock not low");

endmodule
